// *** rtl/pgc_pkg.sv ***
// constants, types and sequence helper for the pattern generator and checker
package pgc_pkg;

  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTL = 8'h71;
  localparam logic [ADDR_W-1:0] ADDR_STAT_ERR = 8'h72;
  localparam logic [ADDR_W-1:0] ADDR_EVT = 8'h73;

  // pattern_control fields
  localparam int CTL_SEL_LSB = 0;
  localparam int CTL_TX_PATTERN_INVERT_BIT = 2;
  localparam int CTL_RX_PATTERN_INVERT_BIT = 3;
  // pattern_status_error_control fields
  localparam int SEC_LOCKEN_BIT = 0;
  localparam int SEC_LOCKED_BIT = 1;
  localparam int SEC_INJ_BIT = 2;
  localparam int SEC_ERREN_BIT = 3;
  // pattern_event_flags fields
  localparam int EVT_LOCK_BIT = 0;
  localparam int EVT_ERR_BIT = 3;

  localparam logic [1:0] SEL_2E15 = 2'h0;
  localparam logic [1:0] SEL_2E20 = 2'h1;
  localparam logic [1:0] SEL_2E11 = 2'h2;

  localparam int LFSR_W = 20;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 20'hfffff;
  localparam logic [LFSR_W-1:0] MASK15 = 20'h07fff;
  localparam logic [LFSR_W-1:0] MASK20 = 20'hfffff;
  localparam logic [LFSR_W-1:0] MASK11 = 20'h007ff;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;
  localparam int TAP20_A = 19;
  localparam int TAP20_B = 16;
  localparam int TAP11_A = 10;
  localparam int TAP11_B = 8;

  localparam int WIN_BITS = 48;
  localparam int LOCK_BITS = 48;
  localparam int ERR_LIMIT = 10;
  localparam int CNT_W = 6;
  localparam int ERR_W = 4;

  typedef struct packed {
    logic rx_inv;
    logic tx_inv;
    logic [1:0] seq_sel;
    logic err_en;
    logic inject;
    logic lock_en;
    logic flag_err;
    logic flag_lock;
    logic [REG_W-1:0] rd_data;
    logic irq_n;
  } pgc_top_st_t;

  localparam pgc_top_st_t TOP_RESET = '{irq_n: 1'b1, rd_data: 8'h00, default: 1'b0};

  typedef struct packed {
    logic [LFSR_W-1:0] lfsr;
    logic tx_bit;
  } pgc_gen_st_t;

  typedef struct packed {
    logic [LFSR_W-1:0] shreg;
    logic locked;
    logic [CNT_W-1:0] good_cnt;
    logic [CNT_W-1:0] win_cnt;
    logic [ERR_W-1:0] err_cnt;
  } pgc_chk_st_t;

  // next sequence bit; an all-zero state is kicked out by forcing a one
  function automatic logic pgc_feedback(input logic [LFSR_W-1:0] s, input logic [1:0] sel);
    logic [LFSR_W-1:0] m;
    logic t;
    case (sel)
      SEL_2E20: begin
        m = MASK20;
        t = s[TAP20_A] ^ s[TAP20_B];
      end
      SEL_2E11: begin
        m = MASK11;
        t = s[TAP11_A] ^ s[TAP11_B];
      end
      default: begin
        m = MASK15;
        t = s[TAP15_A] ^ s[TAP15_B];
      end
    endcase
    return t | ((s & m) == '0);
  endfunction

endpackage

// *** rtl/pgc_if.sv ***
// internal links between register logic, generator and checker
`timescale 1ns/1ns
interface pgc_if;
  logic tx_bit_en;
  logic [1:0] seq_sel;
  logic tx_invert;
  logic inject_req;
  logic inject_done;
  logic tx_bit;
  logic rx_bit_en;
  logic rx_bit;
  logic locked;
  logic bit_err;
  logic lock_chg;

  modport gen (input tx_bit_en, seq_sel, tx_invert, inject_req, output tx_bit, inject_done);
  modport chk (input rx_bit_en, rx_bit, seq_sel, output locked, bit_err, lock_chg);
  modport ctl (output tx_bit_en, seq_sel, tx_invert, inject_req, rx_bit_en, rx_bit,
               input tx_bit, inject_done, locked, bit_err, lock_chg);
endinterface

// *** rtl/pgc_gen.sv ***
// transmit sequence generator with inversion and single error injection
`timescale 1ns/1ns
module pgc_gen (
  input wire logic sys_clk,
  input wire logic rstn,
  pgc_if.gen g
);
  pgc_pkg::pgc_gen_st_t st_reg;
  pgc_pkg::pgc_gen_st_t st_next;
  logic fb;

  assign fb = pgc_pkg::pgc_feedback(st_reg.lfsr, g.seq_sel);
  assign g.inject_done = g.tx_bit_en & g.inject_req;
  assign g.tx_bit = st_reg.tx_bit;

  always_comb begin
    st_next = st_reg;
    if (g.tx_bit_en) begin
      st_next.lfsr = {st_reg.lfsr[pgc_pkg::LFSR_W-2:0], fb};
      st_next.tx_bit = fb ^ g.tx_invert ^ g.inject_req;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '{lfsr: pgc_pkg::LFSR_SEED, tx_bit: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  property p_gen_invert;
    @(posedge sys_clk) disable iff (!rstn)
    (g.tx_bit_en && !g.inject_req) |=> (st_reg.tx_bit == ($past(fb) ^ $past(g.tx_invert)));
  endproperty
  a_gen_invert: assert property (p_gen_invert) else $error("tx bit not sequence xor invert");

  property p_gen_inject;
    @(posedge sys_clk) disable iff (!rstn)
    (g.tx_bit_en && g.inject_req) |=> (st_reg.tx_bit != ($past(fb) ^ $past(g.tx_invert)));
  endproperty
  a_gen_inject: assert property (p_gen_inject) else $error("injected bit not corrupted");
endmodule

// *** rtl/pgc_chk.sv ***
// receive sequence checker with lock tracking
`timescale 1ns/1ns
module pgc_chk #(
  parameter int WIN_BITS = pgc_pkg::WIN_BITS,
  parameter int LOCK_BITS = pgc_pkg::LOCK_BITS,
  parameter int ERR_LIMIT = pgc_pkg::ERR_LIMIT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  pgc_if.chk c
);
  localparam logic [pgc_pkg::CNT_W-1:0] WIN_LAST = pgc_pkg::CNT_W'(WIN_BITS - 1);
  localparam logic [pgc_pkg::CNT_W-1:0] LOCK_LAST = pgc_pkg::CNT_W'(LOCK_BITS - 1);
  localparam logic [pgc_pkg::ERR_W-1:0] ERR_LAST = pgc_pkg::ERR_W'(ERR_LIMIT - 1);

  pgc_pkg::pgc_chk_st_t st_reg;
  pgc_pkg::pgc_chk_st_t st_next;
  logic expect_bit;
  logic mism;

  assign expect_bit = pgc_pkg::pgc_feedback(st_reg.shreg, c.seq_sel);
  assign mism = c.rx_bit ^ expect_bit;
  assign c.locked = st_reg.locked;
  assign c.bit_err = c.rx_bit_en & st_reg.locked & mism;
  assign c.lock_chg = c.rx_bit_en & (st_next.locked != st_reg.locked);

  always_comb begin
    st_next = st_reg;
    if (c.rx_bit_en) begin
      if (st_reg.locked) begin
        st_next.shreg = {st_reg.shreg[pgc_pkg::LFSR_W-2:0], expect_bit};
        if (mism && st_reg.err_cnt == ERR_LAST) begin
          st_next.locked = 1'b0;
          st_next.good_cnt = '0;
          st_next.win_cnt = '0;
          st_next.err_cnt = '0;
        end else if (st_reg.win_cnt == WIN_LAST) begin
          st_next.win_cnt = '0;
          st_next.err_cnt = '0;
        end else begin
          st_next.win_cnt = st_reg.win_cnt + 1'b1;
          st_next.err_cnt = st_reg.err_cnt + {{(pgc_pkg::ERR_W-1){1'b0}}, mism};
        end
      end else begin
        st_next.shreg = {st_reg.shreg[pgc_pkg::LFSR_W-2:0], c.rx_bit};
        if (mism) begin
          st_next.good_cnt = '0;
        end else if (st_reg.good_cnt == LOCK_LAST) begin
          st_next.locked = 1'b1;
          st_next.good_cnt = '0;
          st_next.win_cnt = '0;
          st_next.err_cnt = '0;
        end else begin
          st_next.good_cnt = st_reg.good_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_chk_lose;
    @(posedge sys_clk) disable iff (!rstn)
    (c.rx_bit_en && st_reg.locked && mism && st_reg.err_cnt == ERR_LAST) |=> !st_reg.locked;
  endproperty
  a_chk_lose: assert property (p_chk_lose) else $error("lock kept after error limit");

  property p_chk_gain;
    @(posedge sys_clk) disable iff (!rstn)
    (c.rx_bit_en && !st_reg.locked && !mism && st_reg.good_cnt == LOCK_LAST) |=> st_reg.locked;
  endproperty
  a_chk_gain: assert property (p_chk_gain) else $error("no lock after clean run");
endmodule

// *** rtl/pgc_top.sv ***
// pattern_gen_checker: register file, event flags, interrupt and sub-blocks
`timescale 1ns/1ns
module pgc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [pgc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pgc_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pgc_pkg::REG_W-1:0] reg_rdata,
  input wire logic tx_bit_en,
  output logic tx_data,
  input wire logic rx_bit_en,
  input wire logic rx_data,
  output logic irq_n
);
  pgc_pkg::pgc_top_st_t st_reg;
  pgc_pkg::pgc_top_st_t st_next;
  logic wr_ctl;
  logic wr_sec;
  logic wr_evt;
  logic clr_err;
  logic clr_lock;

  pgc_if ifc ();

  pgc_gen u_gen (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .g(ifc.gen)
  );

  pgc_chk u_chk (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .c(ifc.chk)
  );

  assign ifc.tx_bit_en = tx_bit_en;
  assign ifc.rx_bit_en = rx_bit_en;
  assign ifc.seq_sel = st_reg.seq_sel;
  assign ifc.tx_invert = st_reg.tx_inv;
  assign ifc.inject_req = st_reg.inject;
  assign ifc.rx_bit = rx_data ^ st_reg.rx_inv;

  assign wr_ctl = reg_wr && (reg_addr == pgc_pkg::ADDR_CTL);
  assign wr_sec = reg_wr && (reg_addr == pgc_pkg::ADDR_STAT_ERR);
  assign wr_evt = reg_wr && (reg_addr == pgc_pkg::ADDR_EVT);
  assign clr_err = wr_evt && reg_wdata[pgc_pkg::EVT_ERR_BIT];
  assign clr_lock = wr_evt && reg_wdata[pgc_pkg::EVT_LOCK_BIT];

  assign reg_rdata = st_reg.rd_data;
  assign tx_data = ifc.tx_bit;
  assign irq_n = st_reg.irq_n;

  always_comb begin
    st_next = st_reg;
    if (wr_ctl) begin
      st_next.rx_inv = reg_wdata[pgc_pkg::CTL_RX_PATTERN_INVERT_BIT];
      st_next.tx_inv = reg_wdata[pgc_pkg::CTL_TX_PATTERN_INVERT_BIT];
      st_next.seq_sel = reg_wdata[pgc_pkg::CTL_SEL_LSB +: 2];
    end
    if (ifc.inject_done) begin
      st_next.inject = 1'b0;
    end
    if (wr_sec) begin
      st_next.err_en = reg_wdata[pgc_pkg::SEC_ERREN_BIT];
      st_next.lock_en = reg_wdata[pgc_pkg::SEC_LOCKEN_BIT];
      st_next.inject = reg_wdata[pgc_pkg::SEC_INJ_BIT];
    end
    if (clr_err) begin
      st_next.flag_err = 1'b0;
    end
    if (ifc.bit_err) begin
      st_next.flag_err = 1'b1;
    end
    if (clr_lock) begin
      st_next.flag_lock = 1'b0;
    end
    if (ifc.lock_chg) begin
      st_next.flag_lock = 1'b1;
    end
    st_next.rd_data = '0;
    if (reg_rd) begin
      case (reg_addr)
        pgc_pkg::ADDR_CTL: begin
          st_next.rd_data[pgc_pkg::CTL_RX_PATTERN_INVERT_BIT] = st_reg.rx_inv;
          st_next.rd_data[pgc_pkg::CTL_TX_PATTERN_INVERT_BIT] = st_reg.tx_inv;
          st_next.rd_data[pgc_pkg::CTL_SEL_LSB +: 2] = st_reg.seq_sel;
        end
        pgc_pkg::ADDR_STAT_ERR: begin
          st_next.rd_data[pgc_pkg::SEC_ERREN_BIT] = st_reg.err_en;
          st_next.rd_data[pgc_pkg::SEC_INJ_BIT] = st_reg.inject;
          st_next.rd_data[pgc_pkg::SEC_LOCKED_BIT] = ifc.locked;
          st_next.rd_data[pgc_pkg::SEC_LOCKEN_BIT] = st_reg.lock_en;
        end
        pgc_pkg::ADDR_EVT: begin
          st_next.rd_data[pgc_pkg::EVT_ERR_BIT] = st_reg.flag_err;
          st_next.rd_data[pgc_pkg::EVT_LOCK_BIT] = st_reg.flag_lock;
        end
        default: begin
          st_next.rd_data = '0;
        end
      endcase
    end
    st_next.irq_n = !((st_next.flag_err && st_next.err_en) ||
                      (st_next.flag_lock && st_next.lock_en));
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= pgc_pkg::TOP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  property p_rx_invert;
    rx_bit_en |-> (ifc.rx_bit == (rx_data ^ st_reg.rx_inv));
  endproperty
  a_rx_invert: assert property (p_rx_invert) else $error("checker input not inverted");

  property p_inject_once;
    (st_reg.inject && tx_bit_en && !wr_sec) |=> !st_reg.inject ##1 (!st_reg.inject || $past(wr_sec));
  endproperty
  a_inject_once: assert property (p_inject_once) else $error("inject bit not self-cleared");

  property p_inject_waits;
    (st_reg.inject && !tx_bit_en && !wr_sec) |=> st_reg.inject;
  endproperty
  a_inject_waits: assert property (p_inject_waits) else $error("inject dropped without bit");

  property p_err_flag_set;
    (ifc.bit_err) |=> st_reg.flag_err;
  endproperty
  a_err_flag_set: assert property (p_err_flag_set) else $error("bit error not flagged");

  property p_err_flag_cause;
    $rose(st_reg.flag_err) |-> $past(ifc.bit_err) && $past(ifc.locked);
  endproperty
  a_err_flag_cause: assert property (p_err_flag_cause) else $error("error flag without cause");

  property p_lock_flag;
    (rstn && (ifc.locked != $past(ifc.locked))) |-> st_reg.flag_lock;
  endproperty
  a_lock_flag: assert property (p_lock_flag) else $error("lock change not flagged");

  property p_flag_hold;
    (st_reg.flag_err && !clr_err) |=> st_reg.flag_err;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("error flag lost without clear");

  property p_flag_clear;
    (clr_lock && !ifc.lock_chg) |=> !st_reg.flag_lock;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("lock flag not cleared");

  property p_irq_err;
    (st_reg.flag_err && st_reg.err_en) |-> !irq_n;
  endproperty
  a_irq_err: assert property (p_irq_err) else $error("enabled error flag not on irq");

  property p_irq_lock;
    (st_reg.flag_lock && st_reg.lock_en) |-> !irq_n;
  endproperty
  a_irq_lock: assert property (p_irq_lock) else $error("enabled lock flag not on irq");

  property p_irq_idle;
    !((st_reg.flag_err && st_reg.err_en) || (st_reg.flag_lock && st_reg.lock_en)) |-> irq_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq active with nothing enabled");

  property p_reset_vals;
    !$past(rstn) |-> (st_reg == pgc_pkg::TOP_RESET) && irq_n && !ifc.locked;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("state not cleared by reset");

  property p_read_once;
    !reg_rd |=> (reg_rdata == '0);
  endproperty
  a_read_once: assert property (p_read_once) else $error("read data outside answer cycle");

  property p_read_status;
    (reg_rd && reg_addr == pgc_pkg::ADDR_STAT_ERR) |=>
      (reg_rdata[pgc_pkg::SEC_LOCKED_BIT] == $past(ifc.locked));
  endproperty
  a_read_status: assert property (p_read_status) else $error("lock status misread");

  property p_ctl_write;
    wr_ctl |=> ({st_reg.rx_inv, st_reg.tx_inv, st_reg.seq_sel} ==
      $past(reg_wdata[pgc_pkg::CTL_RX_PATTERN_INVERT_BIT:pgc_pkg::CTL_SEL_LSB]));
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write not taken");

  property p_ctl_hold;
    !wr_ctl |=> $stable(st_reg.seq_sel) && $stable(st_reg.tx_inv) && $stable(st_reg.rx_inv);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without write");

  property p_sec_write;
    wr_sec |=> (st_reg.err_en == $past(reg_wdata[pgc_pkg::SEC_ERREN_BIT])) &&
      (st_reg.lock_en == $past(reg_wdata[pgc_pkg::SEC_LOCKEN_BIT]));
  endproperty
  a_sec_write: assert property (p_sec_write) else $error("enable write not taken");

  property p_en_hold;
    !wr_sec |=> $stable(st_reg.err_en) && $stable(st_reg.lock_en);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable changed without write");

  property p_inject_write;
    wr_sec |=> (st_reg.inject == $past(reg_wdata[pgc_pkg::SEC_INJ_BIT]));
  endproperty
  a_inject_write: assert property (p_inject_write) else $error("inject write not taken");

  property p_lock_hold;
    (st_reg.flag_lock && !clr_lock) |=> st_reg.flag_lock;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock flag lost without clear");

  property p_err_clear;
    (clr_err && !ifc.bit_err) |=> !st_reg.flag_err;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_lock_set;
    ifc.lock_chg |=> st_reg.flag_lock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock change flag not set");

  property p_lock_flag_cause;
    $rose(st_reg.flag_lock) |-> $past(ifc.lock_chg);
  endproperty
  a_lock_flag_cause: assert property (p_lock_flag_cause) else $error("lock flag without cause");

  property p_err_mask;
    (st_reg.flag_err && !st_reg.err_en && !(st_reg.flag_lock && st_reg.lock_en)) |-> irq_n;
  endproperty
  a_err_mask: assert property (p_err_mask) else $error("masked error flag on irq");

  property p_lock_mask;
    (st_reg.flag_lock && !st_reg.lock_en && !(st_reg.flag_err && st_reg.err_en)) |-> irq_n;
  endproperty
  a_lock_mask: assert property (p_lock_mask) else $error("masked lock flag on irq");

  property p_read_ctl;
    (reg_rd && reg_addr == pgc_pkg::ADDR_CTL) |=>
      (reg_rdata[pgc_pkg::CTL_RX_PATTERN_INVERT_BIT:pgc_pkg::CTL_SEL_LSB] ==
       {$past(st_reg.rx_inv), $past(st_reg.tx_inv), $past(st_reg.seq_sel)});
  endproperty
  a_read_ctl: assert property (p_read_ctl) else $error("control misread");

  property p_read_evt;
    (reg_rd && reg_addr == pgc_pkg::ADDR_EVT) |=>
      (reg_rdata[pgc_pkg::EVT_ERR_BIT] == $past(st_reg.flag_err)) &&
      (reg_rdata[pgc_pkg::EVT_LOCK_BIT] == $past(st_reg.flag_lock));
  endproperty
  a_read_evt: assert property (p_read_evt) else $error("event flags misread");

  property p_read_unmapped;
    (reg_rd && reg_addr != pgc_pkg::ADDR_CTL && reg_addr != pgc_pkg::ADDR_STAT_ERR &&
     reg_addr != pgc_pkg::ADDR_EVT) |=> (reg_rdata == '0);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_locked_ro;
    (wr_sec && !rx_bit_en) |=> $stable(ifc.locked);
  endproperty
  a_locked_ro: assert property (p_locked_ro) else $error("lock status written");

  property p_reserved_zero;
    reg_rdata[pgc_pkg::REG_W-1:pgc_pkg::SEC_ERREN_BIT+1] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read bits set");

  property p_cov_lock;
    !ifc.locked ##1 ifc.locked;
  endproperty
  c_cov_lock: cover property (p_cov_lock);

  property p_cov_unlock;
    ifc.locked ##1 !ifc.locked;
  endproperty
  c_cov_unlock: cover property (p_cov_unlock);

  property p_cov_inject;
    st_reg.inject && tx_bit_en;
  endproperty
  c_cov_inject: cover property (p_cov_inject);

  property p_cov_irq;
    irq_n ##1 !irq_n;
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_err;
    ifc.bit_err;
  endproperty
  c_cov_err: cover property (p_cov_err);
endmodule

// *** testbench/tb_top.sv ***
// self-checking testbench for the pattern generator and checker
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [pgc_pkg::ADDR_W-1:0] reg_addr = 8'h00;
  logic [pgc_pkg::REG_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [pgc_pkg::REG_W-1:0] reg_rdata;
  logic tx_bit_en = 1'b0;
  logic tx_data;
  logic rx_bit_en = 1'b0;
  logic rx_data = 1'b0;
  logic irq_n;
  int err_count = 0;
  int check_count = 0;
  int seed = 87;
  logic [7:0] rd_q[$];
  logic tx_q[$];
  logic rd_seen = 1'b0;
  logic tx_seen = 1'b0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] v;
  logic inj_pend = 1'b0;
  logic [19:0] tx_s = 20'hfffff;
  logic [19:0] rx_s = 20'hfffff;

  pgc_top uut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .tx_bit_en(tx_bit_en),
    .tx_data(tx_data),
    .rx_bit_en(rx_bit_en),
    .rx_data(rx_data),
    .irq_n(irq_n)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // reference sequence step: two-tap feedback, all-zero state forces a one
  function automatic logic nxt(input logic [19:0] s, input logic [1:0] sel);
    logic t;
    logic [19:0] m;
    t = (sel == 2'h1) ? s[19] ^ s[16] : (sel == 2'h2) ? s[10] ^ s[8] : s[14] ^ s[13];
    m = (sel == 2'h1) ? 20'hfffff : (sel == 2'h2) ? 20'h007ff : 20'h07fff;
    return t | ((s & m) == 20'h00000);
  endfunction

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: read data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s is %b, expected %b", $time, what, got, exp);
    end
  endtask

  // result watcher: read data and transmit bits one cycle after their strobe
  always @(posedge sys_clk) begin
    rd_seen <= reg_rd;
    tx_seen <= tx_bit_en;
    if (rd_seen && rd_q.size() > 0) chk_byte(reg_rdata, rd_q.pop_front());
    if (tx_seen && tx_q.size() > 0) chk_bit(tx_data, tx_q.pop_front(), "tx bit");
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    if (a == pgc_pkg::ADDR_CTL) ctl = d;
    if (a == pgc_pkg::ADDR_STAT_ERR) inj_pend = d[2];
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic irq_is(input logic exp);
    @(negedge sys_clk);
    chk_bit(irq_n, exp, "irq_n");
  endtask

  task automatic tx_run(input int cnt);
    logic b;
    repeat (cnt) begin
      @(posedge sys_clk);
      b = 1'($random(seed));
      tx_bit_en <= b;
      if (b) begin
        tx_s = {tx_s[18:0], nxt(tx_s, ctl[1:0])};
        tx_q.push_back(tx_s[0] ^ ctl[2] ^ inj_pend);
        inj_pend = 1'b0;
      end
    end
    @(posedge sys_clk);
    tx_bit_en <= 1'b0;
  endtask

  // random-gap receive stream; the first nflip bits sent are wrong
  task automatic rx_run(input int cnt, input int nflip, input logic stop);
    logic b;
    for (int i = 0; i < cnt; i++) begin
      @(posedge sys_clk);
      b = 1'($random(seed));
      rx_bit_en <= b;
      if (b) begin
        rx_s = {rx_s[18:0], nxt(rx_s, ctl[1:0])};
        rx_data <= rx_s[0] ^ ctl[3] ^ (nflip > 0);
        nflip--;
      end else begin
        rx_data <= 1'($random(seed));
      end
      if (stop) begin
        @(negedge sys_clk);
        if (irq_n === 1'b0) break;
      end
    end
    @(posedge sys_clk);
    rx_bit_en <= 1'b0;
  endtask

  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(pgc_pkg::ADDR_CTL, 8'h00);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    rd(pgc_pkg::ADDR_EVT, 8'h00);
    irq_is(1'b1);
    wr(8'h74, 8'hff);
    rd(8'h74, 8'h00);
    wr(pgc_pkg::ADDR_STAT_ERR, 8'hff);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h0d);
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    v = 8'($random(seed));
    wr(pgc_pkg::ADDR_CTL, v);
    rd(pgc_pkg::ADDR_CTL, v & 8'h0f);
    end_test("registers");
    // every sequence code, plain and inverted
    for (int s = 0; s < 8; s++) begin
      wr(pgc_pkg::ADDR_CTL, {5'h00, 1'(s % 2), 2'(s / 2)});
      tx_run(60);
    end
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h04);
    tx_run(30);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    end_test("generator");
    // lock on the 20-bit sequence
    wr(pgc_pkg::ADDR_CTL, 8'h01);
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h01);
    rx_run(400, 0, 1'b1);
    irq_is(1'b0);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h03);
    rd(pgc_pkg::ADDR_EVT, 8'h01);
    rx_run(40, 9, 1'b0);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h03);
    rd(pgc_pkg::ADDR_EVT, 8'h09);
    wr(pgc_pkg::ADDR_EVT, 8'h00);
    rd(pgc_pkg::ADDR_EVT, 8'h09);
    wr(pgc_pkg::ADDR_EVT, 8'h01);
    rd(pgc_pkg::ADDR_EVT, 8'h08);
    irq_is(1'b1);
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h09);
    irq_is(1'b0);
    wr(pgc_pkg::ADDR_EVT, 8'h08);
    irq_is(1'b1);
    rd(pgc_pkg::ADDR_EVT, 8'h00);
    end_test("lock and flags");
    // loss of lock, then mismatches while unlocked
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    rx_run(120, 120, 1'b0);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    rd(pgc_pkg::ADDR_EVT, 8'h09);
    wr(pgc_pkg::ADDR_EVT, 8'h09);
    rx_run(60, 60, 1'b0);
    rd(pgc_pkg::ADDR_EVT, 8'h00);
    // relock on inverted 11-bit data
    wr(pgc_pkg::ADDR_CTL, 8'h0a);
    wr(pgc_pkg::ADDR_STAT_ERR, 8'h01);
    rx_run(400, 0, 1'b1);
    irq_is(1'b0);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h03);
    end_test("loss and relock");
    // second reset in mid-run
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    ctl = 8'h00;
    inj_pend = 1'b0;
    tx_s = 20'hfffff;
    rd(pgc_pkg::ADDR_CTL, 8'h00);
    rd(pgc_pkg::ADDR_STAT_ERR, 8'h00);
    rd(pgc_pkg::ADDR_EVT, 8'h00);
    irq_is(1'b1);
    tx_run(40);
    end_test("second reset");
    repeat (5) @(posedge sys_clk);
    finish_test();
  end
endmodule
